// ===== dv/rlt_host_model.sv
// Purpose: Host-side model of the read latency table.
// Assumes: Single-data-rate reads, commands 0 to 5.
// Notes: Gives the counts the host inserts and each table byte.
`timescale 1ns/10ps
module rlt_host_model (
  input wire logic [1:0] lat_code, // Code.
  input wire logic top_band, // 133 MHz row.
  input wire logic [2:0] cmd, // Read kind.
  input wire logic [6:0] addr, // Table offset.
  output logic [15:0] exp_lk, // Mode, dummy.
  output logic [7:0] exp_byte // Table byte.
);
  localparam logic [7:0] HDR [18] = '{8'h90, 8'h56, 8'h06, 8'h0e, 8'h46, 8'h43, 8'h03,
    8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
  localparam logic [7:0] FRQ [5] = '{8'h32, 8'h50, 8'h5a, 8'h68, 8'h85};
  localparam logic [7:0] CODE [5] = '{8'h03, 8'h00, 8'h01, 8'h02, 8'h02};
  int r;
  int p;
  logic [15:0] t;
  // The host sends the high byte as mode cycles, then the low byte as dummy cycles.
  function automatic logic [15:0] lk(input int r, input int c);
    if ((c == 0 && r > 0) || (r == 4 && c > 1)) return 16'hffff;
    if (c < 4) return r == 0 ? 16'h0000 : 16'h0008;
    if (c == 4) return r < 2 ? 16'h0004 : 16'h0003 + 16'(r);
    return r == 0 ? 16'h0201 : (r == 3 ? 16'h0205 : 16'h0204);
  endfunction
  always_comb begin
    r = lat_code == 2'h3 ? 0 : int'(lat_code) + 1 + int'(top_band && lat_code == 2'h2);
    exp_lk = lk(r, int'(cmd));
    p = int'(addr) - 18;
    t = lk(p / 14, (p % 14 - 2) / 2);
    exp_byte = p % 2 == 0 ? t[15:8] : t[7:0];
    if (addr < 7'h12) exp_byte = HDR[addr];
    if (addr >= 7'h58) exp_byte = 8'hff;
    if (addr >= 7'h12 && addr < 7'h58 && p % 14 == 0) exp_byte = FRQ[p / 14];
    if (addr >= 7'h12 && addr < 7'h58 && p % 14 == 1) exp_byte = CODE[p / 14];
  end
endmodule

// ===== dv/rlt_lookup_monitor.sv
// Purpose: Port checker for the latency lookup.
// Assumes: One clock domain.
// Notes: Request fields are captured at the taking edge.
`timescale 1ns/10ps
module rlt_lookup_monitor (
  input wire logic mclk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic req, // Request.
  input wire logic [1:0] lat_code, // Code.
  input wire logic top_band, // Band.
  input wire logic [2:0] cmd, // Kind.
  input wire logic busy, // Busy.
  input wire logic done, // Done.
  input wire logic [7:0] mode_cycles, // Mode.
  input wire logic [7:0] dummy_cycles, // Dummy.
  input wire logic unsupported, // Refused.
  input wire logic tbl_rd, // Strobe.
  input wire logic tbl_ack // Ack.
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [5:0] cap;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap <= 6'h00;
    end else if (req && !busy) begin
      cap <= {top_band, lat_code, cmd};
    end
  end
  sequence s_take;
    req && !busy;
  endsequence
  a_done_latency: assert property (s_take |-> ##[4:5] done) else $error("late");
  a_busy_span: assert property (s_take |=> busy [*3]) else $error("busy");
  a_unsup_flag: assert property (done |-> unsupported == (mode_cycles == 8'hff ||
    dummy_cycles == 8'hff)) else $error("flag");
  a_code11_zero: assert property (done && cap[4:3] == 2'h3 && cap[2:0] inside {3'h1, 3'h2, 3'h3}
    |-> mode_cycles == 8'h00 && dummy_cycles == 8'h00) else $error("c11");
  a_plain_refused: assert property (done && cap[4:3] != 2'h3 && cap[2:0] == 3'h0
    |-> unsupported) else $error("read");
  a_fast_eight: assert property (done && cap[4:3] != 2'h3 && cap[2:0] == 3'h1
    |-> mode_cycles == 8'h00 && dummy_cycles == 8'h08) else $error("fast");
  a_dio_five: assert property (done && cap[4:3] == 2'h1 && cap[2:0] == 3'h4
    |-> dummy_cycles == 8'h05) else $error("dio");
  a_qio_code00: assert property (done && cap[4:3] == 2'h0 && cap[2:0] == 3'h5
    |-> mode_cycles == 8'h02 && dummy_cycles == 8'h04) else $error("qio");
  a_top_only: assert property (done && cap[5:3] == 3'h6 && cap[2:0] > 3'h1
    |-> unsupported) else $error("top");
  a_tbl_answer: assert property (tbl_rd && !busy && !req |-> ##[2:3] tbl_ack)
    else $error("ack");
endmodule
bind rlt_lookup rlt_lookup_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .req(req),
  .lat_code(lat_code), .top_band(top_band), .cmd(cmd), .busy(busy), .done(done),
  .mode_cycles(mode_cycles), .dummy_cycles(dummy_cycles), .unsupported(unsupported),
  .tbl_rd(tbl_rd), .tbl_ack(tbl_ack));

// ===== dv/rlt_lookup_tb_top.sv
// Purpose: Self-checking bench for the latency lookup.
// Assumes: Inputs change at the falling edge.
// Notes: Every code, band and command, then random ones, then the whole table.
`timescale 1ns/10ps
module rlt_lookup_tb_top;
  logic mclk = 0;
  logic rst_n = 0;
  logic req = 0;
  logic top_band = 0;
  logic tbl_rd = 0;
  logic [1:0] lat_code = 0;
  logic [2:0] cmd = 0;
  logic [6:0] tbl_addr = 0;
  logic busy, done, unsupported, tbl_ack;
  logic [7:0] mode_cycles, dummy_cycles, tbl_data, exp_byte;
  logic [15:0] exp_lk;
  logic [16:0] q_lk[$];
  logic [7:0] q_tb[$];
  int n_mismatch = 0;
  int checked = 0;
  int seed = 61995;
  always #25 mclk = ~mclk;
  rlt_lookup i_dut (.mclk(mclk), .rst_n(rst_n), .req(req), .lat_code(lat_code),
    .top_band(top_band), .cmd(cmd), .busy(busy), .done(done), .mode_cycles(mode_cycles),
    .dummy_cycles(dummy_cycles), .unsupported(unsupported), .tbl_addr(tbl_addr),
    .tbl_rd(tbl_rd), .tbl_ack(tbl_ack), .tbl_data(tbl_data));
  rlt_host_model i_host (.lat_code(lat_code), .top_band(top_band), .cmd(cmd),
    .addr(tbl_addr), .exp_lk(exp_lk), .exp_byte(exp_byte));
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic miss(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  always @(posedge mclk) begin
    if (done === 1'b1) begin
      checked++;
      if (q_lk.size() == 0 || {unsupported, mode_cycles, dummy_cycles} !== q_lk.pop_front())
        miss("lookup");
    end
    if (tbl_ack === 1'b1) begin
      checked++;
      if (q_tb.size() == 0 || tbl_data !== q_tb.pop_front()) miss("table");
    end
  end
  // A second request and a table strobe land while busy; both must be ignored.
  task automatic look(input logic [1:0] c, input logic t, input logic [2:0] k);
    int n;
    @(negedge mclk);
    lat_code = c;
    top_band = t;
    cmd = k;
    req = 1;
    #1 q_lk.push_back({exp_lk[15:8] == 8'hff || exp_lk[7:0] == 8'hff, exp_lk});
    @(negedge mclk);
    cmd = 3'h1;
    tbl_rd = 1;
    @(negedge mclk);
    req = 0;
    tbl_rd = 0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (n == 20) miss("no done");
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    rst_n = 1;
    for (int i = 0; i < 48; i++) look(2'(i / 6), i >= 24, 3'(i % 6));
    for (int i = 0; i < 20; i++) look(2'($random(seed)), 1'($random(seed)),
      3'(($random(seed) & 32'hff) % 6));
    for (int a = 0; a < 96; a++) begin
      @(negedge mclk);
      tbl_addr = 7'(a);
      tbl_rd = 1;
      #1 q_tb.push_back(exp_byte);
    end
    @(negedge mclk);
    tbl_rd = 0;
    repeat (5) @(negedge mclk);
    if (q_lk.size() + q_tb.size() != 0) miss("missing result");
    test_done();
  end
  initial begin
    #200000;
    miss("timeout");
    test_done();
  end
endmodule

// ===== logic/rlt_lookup.sv
// Purpose: Resolves mode and dummy cycle counts for a read command and band.
// Assumes: Requests come from logic on mclk; table reads also come from mclk logic.
// Notes: Band 10b has two rows, so the frequency band selects the row, not the code.
// Contract
// - Row two is the 50 MHz band with latency code 11b.
// - Code 11b: single, dual, quad out zero; dual I/O 4; quad I/O 2+1.
// - Code 00b to 80 MHz; plain Read unsupported there.
// - Code 00b: fast/dual/quad out 8 dummy; dual I/O 4; quad I/O 2+4.
// - Code 01b to 90 MHz: no Read; outs 8; dual I/O 5; quad I/O 2+4.
// - Code 10b to 104 MHz: no Read; outs 8; dual I/O 6; quad I/O 2+5.
// - At 133 MHz under 10b only Fast Read works, with 8 dummy cycles.
// - A table entry of all ones marks the command unsupported.
`timescale 1ns/10ps
module rlt_lookup
  import rlt_pkg::*;
(
  input wire logic mclk,          // System clock, 20 MHz.
  input wire logic rst_n,         // Asynchronous reset, active low.
  input wire logic req,           // Lookup request, one-cycle pulse.
  input wire logic [1:0] lat_code, // Configured latency code.
  input wire logic top_band,      // With code 10b, selects the 133 MHz row.
  input wire logic [2:0] cmd,     // Read command kind, rlt_cmd_t encoding.
  output logic busy,              // High while a lookup runs.
  output logic done,              // Result valid, one-cycle pulse.
  output logic [7:0] mode_cycles, // Mode cycles after the address.
  output logic [7:0] dummy_cycles, // Dummy cycles after the mode cycles.
  output logic unsupported,       // Command not allowed in this band.
  input wire logic [6:0] tbl_addr, // Parameter table byte offset for readout.
  input wire logic tbl_rd,        // Parameter table read strobe.
  output logic tbl_ack,           // Table byte valid, one-cycle pulse.
  output logic [7:0] tbl_data     // Table byte read.
);

  rlt_rom_if rom_bus ();
  rlt_state_t state;
  logic [6:0] base;
  logic [1:0] step;
  logic [7:0] mode_byte;
  logic tbl_pend;

  rlt_rom u_rom (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(rom_bus)
  );

  // Code 10b maps to two rows; the band input picks the 133 MHz one.
  function automatic logic [2:0] row_of(input logic [1:0] code, input logic top);
    case (code)
      2'b11: row_of = 3'h0;
      2'b00: row_of = 3'h1;
      2'b01: row_of = 3'h2;
      2'b10: row_of = top ? 3'h4 : 3'h3;
      default: row_of = 3'h0;
    endcase
  endfunction

  function automatic logic [6:0] row_base(input logic [2:0] row, input logic [2:0] c);
    logic [6:0] r;
    r = RLT_ROW2_OFS + 7'(row * RLT_ROW_STEP);
    row_base = r + RLT_ROW_DATA_OFS + 7'({c, 1'b0});
  endfunction

  assign busy = (state != RLT_ST_IDLE);

  // Table readout is served only when no lookup owns the address port.
  always_comb begin
    if (state == RLT_ST_IDLE && !req) begin
      rom_bus.addr = tbl_addr;
    end else begin
      rom_bus.addr = base + 7'(step);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RLT_ST_IDLE;
      base <= 7'h00;
      step <= 2'h0;
    end else begin
      case (state)
        RLT_ST_IDLE: begin
          step <= 2'h0;
          if (req) begin
            base <= row_base(row_of(lat_code, top_band), cmd);
            state <= RLT_ST_LOOK;
          end
        end
        RLT_ST_LOOK: begin
          if (step == 2'h2) begin
            state <= RLT_ST_DONE;
          end
          step <= step + 2'h1;
        end
        RLT_ST_DONE: state <= RLT_ST_IDLE;
        default: state <= RLT_ST_IDLE;
      endcase
    end
  end

  // Step 0 issues mode address, step 1 captures mode and issues dummy.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_byte <= 8'h00;
      mode_cycles <= 8'h00;
      dummy_cycles <= 8'h00;
      unsupported <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (state == RLT_ST_LOOK && step == 2'h1) begin
        mode_byte <= rom_bus.data;
      end
      if (state == RLT_ST_LOOK && step == 2'h2) begin
        mode_cycles <= mode_byte;
        dummy_cycles <= rom_bus.data;
        unsupported <= (mode_byte == RLT_UNSUP) || (rom_bus.data == RLT_UNSUP);
        done <= 1'b1;
      end
    end
  end

  // Readout requests arriving during a lookup are dropped; tbl_ack shows which landed.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_pend <= 1'b0;
      tbl_ack <= 1'b0;
      tbl_data <= 8'h00;
    end else begin
      tbl_pend <= tbl_rd && state == RLT_ST_IDLE && !req;
      tbl_ack <= tbl_pend;
      if (tbl_pend) begin
        tbl_data <= rom_bus.data;
      end
    end
  end

endmodule

// ===== logic/rlt_rom.sv
// Purpose: Constant latency parameter table read one byte per clock.
// Assumes: Address comes from logic on the same clock.
// Notes: Out-of-range addresses read as the unsupported marker.
`timescale 1ns/10ps
module rlt_rom
  import rlt_pkg::*;
(
  input wire logic mclk,  // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  rlt_rom_if.rom bus      // Byte address in, byte out.
);

  localparam logic [7:0] TBL [RLT_TBL_BYTES] = '{
    RLT_PARAM_ID, RLT_PARAM_LEN, RLT_NUM_ROWS, RLT_ROW_LEN,
    8'h46, 8'h43, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c, 8'h6b, 8'h6c,
    8'hbb, 8'hbc, 8'heb, 8'hec,
    8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h04, 8'h02, 8'h01,
    8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h04, 8'h02, 8'h04,
    8'h5a, 8'h01, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h05, 8'h02, 8'h04,
    8'h68, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08,
    8'h00, 8'h06, 8'h02, 8'h05,
    8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff
  };

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus.data <= 8'h00;
    end else if (int'(bus.addr) < RLT_TBL_BYTES) begin
      bus.data <= TBL[bus.addr];
    end else begin
      bus.data <= RLT_UNSUP;
    end
  end

endmodule

// ===== pkg/rlt_pkg.sv
// Purpose: Shared constants and types for the serial flash read-latency lookup.
// Assumes: Single-data-rate read commands only.
// Notes: Table bytes follow the parameter layout with relative byte offsets.
package rlt_pkg;

  localparam int RLT_TBL_BYTES = 88;
  localparam logic [7:0] RLT_PARAM_ID = 8'h90;
  localparam logic [7:0] RLT_PARAM_LEN = 8'h56;
  localparam logic [7:0] RLT_NUM_ROWS = 8'h06;
  localparam logic [7:0] RLT_ROW_LEN = 8'h0e;
  localparam logic [7:0] RLT_UNSUP = 8'hff;
  localparam logic [6:0] RLT_ROW2_OFS = 7'h12;
  localparam logic [6:0] RLT_ROW_STEP = 7'h0e;
  localparam logic [6:0] RLT_ROW_DATA_OFS = 7'h02;
  localparam logic [2:0] RLT_BAND_ROWS = 3'h5;

  typedef enum logic [2:0] {
    RLT_CMD_READ = 3'h0,
    RLT_CMD_FAST = 3'h1,
    RLT_CMD_DOUT = 3'h2,
    RLT_CMD_QOUT = 3'h3,
    RLT_CMD_DIO = 3'h4,
    RLT_CMD_QIO = 3'h5
  } rlt_cmd_t;

  typedef enum logic [1:0] {
    RLT_BAND_SLOW = 2'h0,
    RLT_BAND_MID = 2'h1,
    RLT_BAND_FAST = 2'h3,
    RLT_BAND_TOP = 2'h2
  } rlt_band_t;

  typedef enum logic [1:0] {
    RLT_ST_IDLE = 2'h0,
    RLT_ST_LOOK = 2'h1,
    RLT_ST_DONE = 2'h3
  } rlt_state_t;

endpackage

// ===== pkg/rlt_rom_if.sv
// Purpose: Carries a byte address and its data between the lookup and its table.
// Assumes: Same clock on both sides.
// Notes: Read data is registered one cycle after the address.
`timescale 1ns/10ps
interface rlt_rom_if;
  logic [6:0] addr;
  logic [7:0] data;
  modport user (output addr, input data);
  modport rom (input addr, output data);
endinterface
